// File: hdl/pwmtb_time_base.sv
// Motor control pulse-width modulation time base with register port
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "pwmtb_cfg.svh"

// Contract
// R1: 15-bit counter with prescaler and postscaler
// R2: Count bit 15 reads direction, read-only
// R3: Enable starts counter; clearing keeps count
// R4: Period match resets or reverses next tick
// R5: Zero period stops count and all events
// R6: Zero period blocks period load while enabled
// R7: Two-bit mode field selects four modes
// R8: Events depend on mode and postscale select
// R9: Free running counts up, wraps to zero
// R10: Free running event per match, postscaled
// R11: Single shot resets and clears enable
// R12: Single shot one event, no postscaler
// R13: Up/down reverses, event at zero, postscaled
// R14: Double update events at zero and match
// R15: Prescale 1/4/16/64, cleared by writes
// R16: Postscale 1 to 16, cleared by writes
// R17: One step per prescaler tick, synchronous
module pwmtb_time_base
  import pwmtb_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [3:0]          address,
  input  wire pwmtb_pkg::pwmtb_word_t writeData,
  input  wire logic                writeStrobe,
  input  wire logic                readStrobe,
  output pwmtb_pkg::pwmtb_word_t   readData,
  output pwmtb_pkg::pwmtb_count_t  timeBaseCount,
  output logic                     countDownFlag,
  output logic                     timeBaseEvent,
  output logic                     specialEventTrigger,
  output logic                     irq
);

  import pwmtb_pkg::*;

  // ===========================================================================
  // Register state
  logic         enable_reg;
  logic [1:0]   modeSel_reg;
  logic [1:0]   preSel_reg;
  logic [3:0]   postSel_reg;
  pwmtb_count_t count_reg;
  pwmtb_count_t count_next;
  logic         dir_reg;
  logic         dir_next;
  pwmtb_count_t period_reg;
  pwmtb_count_t periodBuf_reg;
  pwmtb_count_t special_reg;
  logic [3:0]   postCount_reg;
  logic [1:0]   status_reg;
  logic [1:0]   status_next;
  logic [1:0]   mask_reg;
  logic [1:0]   mask_next;
  pwmtb_word_t  readData_reg;
  logic         event_reg;
  logic         trigger_reg;
  logic         irq_reg;

  // ===========================================================================
  // Decode and event wires
  pwmtb_mode_e  mode;
  logic         ctlWrite;
  logic         cntWrite;
  logic         perWrite;
  logic         spcWrite;
  logic         stsWrite;
  logic         mskWrite;
  logic         preTick;
  logic         running;
  logic         matchHit;
  logic         zeroHit;
  logic         reload;
  logic         postSource;
  logic         postFire;
  logic         directEvent;
  logic         tbEvent;
  logic         specHit;
  pwmtb_word_t  ctlWord;

  // ===========================================================================
  // Functions

  // Terminal count of the prescaler for a select code
  function automatic logic [5:0] preTerminal(input logic [1:0] sel);
    logic [5:0] tc;
    tc = `PWMTB_PRE_TC_1;
    case (sel)
      2'h0: tc = `PWMTB_PRE_TC_1;
      2'h1: tc = `PWMTB_PRE_TC_4;
      2'h2: tc = `PWMTB_PRE_TC_16;
      2'h3: tc = `PWMTB_PRE_TC_64;
    endcase
    return tc;
  endfunction : preTerminal

  // True for a write strobe aimed at one register offset
  function automatic logic hits(input logic strobe, input logic [3:0] addr,
                                input logic [3:0] off);
    return strobe && (addr == off);
  endfunction : hits

  // ===========================================================================
  // Address decode
  assign ctlWrite = hits(writeStrobe, address, `PWMTB_OFF_CONTROL);
  assign cntWrite = hits(writeStrobe, address, `PWMTB_OFF_COUNT);
  assign perWrite = hits(writeStrobe, address, `PWMTB_OFF_PERIOD);
  assign spcWrite = hits(writeStrobe, address, `PWMTB_OFF_SPECIAL);
  assign stsWrite = hits(writeStrobe, address, `PWMTB_OFF_STATUS);
  assign mskWrite = hits(writeStrobe, address, `PWMTB_OFF_MASK);

  // Mode field as an enumerated value
  assign mode = pwmtb_mode_e'(modeSel_reg); // [R7]

  // ===========================================================================
  // Prescaler, cleared by count or control writes
  pwmtb_prescaler #(
    .CNT_W (6)
  ) u_prescaler (
    .clk      (clk),
    .reset    (reset),
    .clear    (ctlWrite || cntWrite), // [R15]
    .terminal (preTerminal(preSel_reg)), // [R15]
    .tick     (preTick)
  );

  // Counter advances only on a tick while enabled with nonzero period
  assign running = enable_reg && (period_reg != '0) && preTick; // [R5] [R17]

  // ===========================================================================
  // Count and direction next state
  always_comb begin
    count_next = count_reg;
    dir_next   = dir_reg;
    matchHit   = 1'b0;
    zeroHit    = 1'b0;
    reload     = 1'b0;
    if (running) begin
      if (mode == PWMTB_FREE || mode == PWMTB_SINGLE) begin
        dir_next = 1'b0;
        if (count_reg == period_reg) begin // [R4]
          count_next = '0; // [R9] [R11]
          matchHit   = 1'b1;
          reload     = 1'b1;
        end else begin
          count_next = count_reg + 15'h0001; // [R1] [R17]
        end
      end else if (!dir_reg) begin
        if (count_reg == period_reg) begin // [R4]
          count_next = count_reg - 15'h0001;
          dir_next   = 1'b1; // [R13]
          matchHit   = 1'b1;
        end else begin
          count_next = count_reg + 15'h0001;
        end
      end else begin
        if (count_reg == '0) begin
          count_next = 15'h0001;
          dir_next   = 1'b0; // [R13]
          zeroHit    = 1'b1;
          reload     = 1'b1;
        end else begin
          count_next = count_reg - 15'h0001;
        end
      end
    end
  end

  // ===========================================================================
  // Interrupt event selection by mode and postscaler
  assign postSource = (mode == PWMTB_FREE && matchHit) || // [R10]
                      (mode == PWMTB_UPDOWN && zeroHit); // [R13]
  assign postFire = postSource && (postCount_reg == postSel_reg); // [R16]
  assign directEvent = (mode == PWMTB_SINGLE && matchHit) || // [R12]
                       (mode == PWMTB_DOUBLE && (matchHit || zeroHit)); // [R14]
  assign tbEvent = directEvent || postFire; // [R8]

  // Special event compare, silent with zero period
  assign specHit = running && (count_reg == special_reg); // [R5]

  // Control register image as software reads it
  assign ctlWord = {enable_reg, 7'h00, postSel_reg, preSel_reg, modeSel_reg};

  // ===========================================================================
  // Control register with hardware self-disable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_reg  <= 1'b0;
      modeSel_reg <= 2'h0;
      preSel_reg  <= 2'h0;
      postSel_reg <= 4'h0;
    end else if (ctlWrite) begin
      enable_reg  <= writeData[`PWMTB_CTL_EN_BIT]; // [R3]
      modeSel_reg <= writeData[`PWMTB_CTL_MODE_MSB:`PWMTB_CTL_MODE_LSB];
      preSel_reg  <= writeData[`PWMTB_CTL_PRE_MSB:`PWMTB_CTL_PRE_LSB];
      postSel_reg <= writeData[`PWMTB_CTL_POST_MSB:`PWMTB_CTL_POST_LSB];
    end else if (mode == PWMTB_SINGLE && matchHit) begin
      enable_reg <= 1'b0; // [R11]
    end
  end

  // Count register; disabling leaves it as it stands
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= `PWMTB_RST_COUNT;
    end else if (cntWrite) begin
      count_reg <= writeData[14:0];
    end else begin
      count_reg <= count_next; // [R3]
    end
  end

  // Direction flag, changed only by the counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next; // [R2]
    end
  end

  // ===========================================================================
  // Period buffer and active period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periodBuf_reg <= `PWMTB_RST_PERIOD;
    end else if (perWrite) begin
      periodBuf_reg <= writeData[14:0];
    end
  end

  // Load when disabled, or at a reload point with nonzero period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      period_reg <= `PWMTB_RST_PERIOD;
    end else if (!enable_reg || (reload && period_reg != '0)) begin // [R6]
      period_reg <= periodBuf_reg;
    end
  end

  // Special event compare value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      special_reg <= `PWMTB_RST_SPECIAL;
    end else if (spcWrite) begin
      special_reg <= writeData[14:0];
    end
  end

  // ===========================================================================
  // Postscaler counter, cleared by count or control writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      postCount_reg <= 4'h0;
    end else if (ctlWrite || cntWrite) begin
      postCount_reg <= 4'h0; // [R16]
    end else if (postSource) begin
      postCount_reg <= postFire ? 4'h0 : postCount_reg + 4'h1; // [R16]
    end
  end

  // ===========================================================================
  // Sticky status: a new event wins over a write-one clear
  always_comb begin
    status_next = status_reg;
    if (stsWrite) begin
      status_next = status_reg & ~writeData[1:0];
    end
    status_next[`PWMTB_IRQ_TB_BIT]  = status_next[`PWMTB_IRQ_TB_BIT] |
                                      tbEvent;
    status_next[`PWMTB_IRQ_SPC_BIT] = status_next[`PWMTB_IRQ_SPC_BIT] |
                                      specHit;
    mask_next = mskWrite ? writeData[1:0] : mask_reg;
  end

  // Status and mask registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= `PWMTB_RST_IRQ;
      mask_reg   <= `PWMTB_RST_IRQ;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  // Interrupt level and event pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_reg     <= 1'b0;
      event_reg   <= 1'b0;
      trigger_reg <= 1'b0;
    end else begin
      irq_reg     <= |(status_next & mask_next);
      event_reg   <= tbEvent; // [R8]
      trigger_reg <= specHit; // [R5]
    end
  end

  // ===========================================================================
  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readData_reg <= 16'h0000;
    end else if (readStrobe) begin
      case (address)
        `PWMTB_OFF_CONTROL:
          readData_reg <= ctlWord; // [R3] [R7]
        `PWMTB_OFF_COUNT:
          readData_reg <= {dir_reg, count_reg}; // [R2]
        `PWMTB_OFF_PERIOD:
          readData_reg <= {1'b0, periodBuf_reg};
        `PWMTB_OFF_SPECIAL:
          readData_reg <= {1'b0, special_reg};
        `PWMTB_OFF_STATUS:
          readData_reg <= {14'h0000, status_reg};
        `PWMTB_OFF_MASK:
          readData_reg <= {14'h0000, mask_reg};
        default:
          readData_reg <= 16'h0000;
      endcase
    end else begin
      readData_reg <= 16'h0000;
    end
  end

  // ===========================================================================
  // Outputs straight from registers
  assign readData            = readData_reg;
  assign timeBaseCount       = count_reg;
  assign countDownFlag       = dir_reg;
  assign timeBaseEvent       = event_reg;
  assign specialEventTrigger = trigger_reg;
  assign irq                 = irq_reg;

endmodule : pwmtb_time_base

// File: hdl/pwmtb_cfg.svh
// Register offsets, field positions, reset values and counts of the time base
`ifndef PWMTB_CFG_SVH
`define PWMTB_CFG_SVH

// ===========================================================================
// Register word offsets
`define PWMTB_OFF_CONTROL 4'h0
`define PWMTB_OFF_COUNT   4'h1
`define PWMTB_OFF_PERIOD  4'h2
`define PWMTB_OFF_SPECIAL 4'h3
`define PWMTB_OFF_STATUS  4'h4
`define PWMTB_OFF_MASK    4'h5

// ===========================================================================
// Field positions
`define PWMTB_CTL_EN_BIT   15
`define PWMTB_CTL_POST_MSB 7
`define PWMTB_CTL_POST_LSB 4
`define PWMTB_CTL_PRE_MSB  3
`define PWMTB_CTL_PRE_LSB  2
`define PWMTB_CTL_MODE_MSB 1
`define PWMTB_CTL_MODE_LSB 0
`define PWMTB_CNT_DIR_BIT  15
`define PWMTB_IRQ_TB_BIT   0
`define PWMTB_IRQ_SPC_BIT  1

// ===========================================================================
// Reset values
`define PWMTB_RST_COUNT   15'h0000
`define PWMTB_RST_PERIOD  15'h0000
`define PWMTB_RST_SPECIAL 15'h0000
`define PWMTB_RST_IRQ     2'h0

// ===========================================================================
// Prescaler terminal counts for divide by 1, 4, 16 and 64
`define PWMTB_PRE_TC_1  6'h00
`define PWMTB_PRE_TC_4  6'h03
`define PWMTB_PRE_TC_16 6'h0f
`define PWMTB_PRE_TC_64 6'h3f

`endif

// File: hdl/pwmtb_pkg.sv
// Types shared by the time base files
package pwmtb_pkg;

  // ===========================================================================
  // Operating modes of the time base
  typedef enum logic [1:0] {
    PWMTB_FREE   = 2'h0,
    PWMTB_SINGLE = 2'h1,
    PWMTB_UPDOWN = 2'h2,
    PWMTB_DOUBLE = 2'h3
  } pwmtb_mode_e;

  typedef logic [14:0] pwmtb_count_t;
  typedef logic [15:0] pwmtb_word_t;

endpackage : pwmtb_pkg

// File: hdl/pwmtb_prescaler.sv
// Input clock prescaler of the time base
`timescale 1ns/1ps

module pwmtb_prescaler #(
  parameter int CNT_W = 6
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] terminal,
  output logic                  tick
);

  logic [CNT_W-1:0] divCount_reg;

  // ===========================================================================
  // Width check
  generate
    if (CNT_W < 6) begin : g_bad_width
      $error("pwmtb_prescaler: CNT_W too small for divide by 64");
    end
  endgenerate

  // Tick on the terminal count, held off in a clearing cycle
  assign tick = !clear && (divCount_reg == terminal);

  // Divider counter, cleared by register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCount_reg <= '0;
    end else if (clear || tick) begin
      divCount_reg <= '0;
    end else begin
      divCount_reg <= divCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule : pwmtb_prescaler

// File: testbench/pwmtb_time_base_properties.sv
// Concurrent checks on the time base ports
`timescale 1ns/1ps
`include "pwmtb_cfg.svh"

// ============================================================
// Port checker
module pwmtb_time_base_chk
  import pwmtb_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic [3:0]             address,
  input wire pwmtb_pkg::pwmtb_word_t  writeData,
  input wire logic                   writeStrobe,
  input wire logic                   readStrobe,
  input wire pwmtb_pkg::pwmtb_word_t  readData,
  input wire pwmtb_pkg::pwmtb_count_t timeBaseCount,
  input wire logic                   countDownFlag,
  input wire logic                   timeBaseEvent,
  input wire logic                   specialEventTrigger,
  input wire logic                   irq
);
  import pwmtb_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Count moved without a software write in front of it
  sequence s_quiet;
    !writeStrobe ##1 timeBaseCount != $past(timeBaseCount);
  endsequence
  property p_step;
    s_quiet |-> timeBaseCount == $past(timeBaseCount) + 15'h1 ||
      timeBaseCount == $past(timeBaseCount) - 15'h1 ||
      timeBaseCount == 15'h0;
  endproperty
  property p_countWrite;
    writeStrobe && address == `PWMTB_OFF_COUNT |=>
      timeBaseCount == $past(writeData[14:0]);
  endproperty
  property p_readIdle;
    !readStrobe |=> readData == 16'h0;
  endproperty
  property p_unmapped;
    readStrobe && address > 4'h5 |=> readData == 16'h0;
  endproperty
  property p_eventPulse;
    timeBaseEvent |=> !timeBaseEvent;
  endproperty
  property p_irqRise;
    $rose(irq) |-> timeBaseEvent || specialEventTrigger ||
      $past(writeStrobe);
  endproperty
  property p_maskOff;
    writeStrobe && address == `PWMTB_OFF_MASK && writeData[1:0] == 2'h0
      |-> ##[1:2] !irq;
  endproperty
  property p_dirFall;
    $fell(countDownFlag) |-> timeBaseCount == 15'h1 ||
      $past(writeStrobe) || $past(writeStrobe, 2);
  endproperty

  a_step: assert property (p_step)
    else $error("count jumped");
  a_countWrite: assert property (p_countWrite)
    else $error("count write lost");
  a_readIdle: assert property (p_readIdle)
    else $error("read data outside slot");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_eventPulse: assert property (p_eventPulse)
    else $error("event longer than a cycle");
  a_irqRise: assert property (p_irqRise)
    else $error("irq rose without cause");
  a_maskOff: assert property (p_maskOff)
    else $error("masked irq stays high");
  a_dirFall: assert property (p_dirFall)
    else $error("direction turned off zero");
endmodule : pwmtb_time_base_chk

bind pwmtb_time_base pwmtb_time_base_chk u_chk (.clk(clk), .reset(reset),
  .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData),
  .timeBaseCount(timeBaseCount), .countDownFlag(countDownFlag),
  .timeBaseEvent(timeBaseEvent),
  .specialEventTrigger(specialEventTrigger), .irq(irq));

// File: testbench/test_pwm_time_base.sv
// Self-checking bench for the time base
`timescale 1ns/1ps
`include "pwmtb_cfg.svh"

// ============================================================
// Bench top
module test_pwm_time_base;
  import pwmtb_pkg::*;
  logic         clk, reset, writeStrobe, readStrobe;
  logic [3:0]   address;
  pwmtb_word_t  writeData, readData, rv;
  pwmtb_count_t timeBaseCount, c;
  logic         countDownFlag, timeBaseEvent, specialEventTrigger, irq;
  int           n_fail, tests_run, evCnt, spCnt, g, n, s;

  pwmtb_time_base dut (.clk(clk), .reset(reset), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData),
    .timeBaseCount(timeBaseCount), .countDownFlag(countDownFlag),
    .timeBaseEvent(timeBaseEvent),
    .specialEventTrigger(specialEventTrigger), .irq(irq));

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Event counters
  always @(posedge clk) begin
    if (timeBaseEvent === 1'b1) evCnt <= evCnt + 1;
    if (specialEventTrigger === 1'b1) spCnt <= spCnt + 1;
  end

  // ============================================================
  // Helpers
  task check(input pwmtb_word_t seen, input pwmtb_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input pwmtb_word_t d);
    @(posedge clk);
    address     <= a;
    writeData   <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output pwmtb_word_t d);
    @(posedge clk);
    address    <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    @(posedge clk);
    d = readData;
  endtask : rd
  function pwmtb_word_t ctl(input logic e, input logic [3:0] po,
                            input logic [1:0] pr, input logic [1:0] md);
    return {e, 7'h0, po, pr, md};
  endfunction : ctl
  task run(input pwmtb_word_t p, input pwmtb_word_t w);
    wr(`PWMTB_OFF_CONTROL, 16'h0);
    wr(`PWMTB_OFF_COUNT, 16'h0);
    wr(`PWMTB_OFF_PERIOD, p);
    wr(`PWMTB_OFF_CONTROL, w);
  endtask : run
  // Clocks between two consecutive events
  task gap(output int q);
    int k;
    k = evCnt;
    for (int i = 0; i < 3000 && evCnt == k; i++) @(posedge clk);
    k = evCnt;
    q = 0;
    while (evCnt == k && q < 3000) begin
      @(posedge clk);
      q++;
    end
  endtask : gap

  // ============================================================
  // Scenarios
  task t_reset;
    rd(`PWMTB_OFF_COUNT, rv);
    check(rv, 16'h0);
    rd(`PWMTB_OFF_PERIOD, rv);
    check(rv, 16'h0);
    rd(4'hf, rv);
    check(rv, 16'h0);
  endtask : t_reset
  task t_free;
    for (int p = 0; p < 4; p++) begin
      run(16'h2, ctl(1'b1, 4'h0, 2'(p), 2'h0));
      gap(g);
      check(16'(g), 16'(3 << (2 * p)));
    end
    run(16'h2, ctl(1'b1, 4'h3, 2'h0, 2'h0));
    gap(g);
    check(16'(g), 16'd12);
  endtask : t_free
  task t_stop;
    run(16'd100, ctl(1'b1, 4'h0, 2'h0, 2'h0));
    repeat (20) @(posedge clk);
    wr(`PWMTB_OFF_CONTROL, 16'h0);
    @(posedge clk);
    c = timeBaseCount;
    repeat (10) @(posedge clk);
    rd(`PWMTB_OFF_COUNT, rv);
    check(rv, {1'b0, c});
    wr(`PWMTB_OFF_COUNT, 16'hffff);
    rd(`PWMTB_OFF_COUNT, rv);
    check(rv, 16'h7fff);
  endtask : t_stop
  task t_single;
    run(16'h2, ctl(1'b1, 4'h3, 2'h0, 2'h1));
    n = evCnt;
    repeat (30) @(posedge clk);
    check(16'(evCnt - n), 16'h1);
    rd(`PWMTB_OFF_CONTROL, rv);
    check(rv, ctl(1'b0, 4'h3, 2'h0, 2'h1));
    rd(`PWMTB_OFF_COUNT, rv);
    check(rv, 16'h0);
  endtask : t_single
  task t_updown;
    run(16'h2, ctl(1'b1, 4'h0, 2'h0, 2'h2));
    gap(g);
    check(16'(g), 16'd4);
    run(16'd20, ctl(1'b1, 4'h1, 2'h0, 2'h2));
    gap(g);
    check(16'(g), 16'd80);
    for (int i = 0; i < 60 && countDownFlag !== 1'b1; i++) @(posedge clk);
    check({15'h0, countDownFlag}, 16'h1);
    wr(`PWMTB_OFF_CONTROL, ctl(1'b0, 4'h0, 2'h0, 2'h2));
    rd(`PWMTB_OFF_COUNT, rv);
    check({15'h0, rv[15]}, 16'h1);
  endtask : t_updown
  task t_double;
    run(16'h3, ctl(1'b1, 4'h3, 2'h0, 2'h3));
    gap(g);
    check(16'(g), 16'd3);
    gap(g);
    check(16'(g), 16'd3);
  endtask : t_double
  task t_irq;
    wr(`PWMTB_OFF_CONTROL, 16'h0);
    rd(`PWMTB_OFF_STATUS, rv);
    check({15'h0, rv[0]}, 16'h1);
    check({15'h0, irq}, 16'h0);
    wr(`PWMTB_OFF_MASK, 16'h1);
    repeat (2) @(posedge clk);
    check({15'h0, irq}, 16'h1);
    wr(`PWMTB_OFF_STATUS, 16'h3);
    repeat (2) @(posedge clk);
    check({15'h0, irq}, 16'h0);
    rd(`PWMTB_OFF_STATUS, rv);
    check(rv, 16'h0);
    // A live event raises the unmasked interrupt
    run(16'h2, ctl(1'b1, 4'h0, 2'h0, 2'h0));
    repeat (6) @(posedge clk);
    check({15'h0, irq}, 16'h1);
    wr(`PWMTB_OFF_CONTROL, 16'h0);
    wr(`PWMTB_OFF_STATUS, 16'h3);
    @(posedge clk);
    check({15'h0, irq}, 16'h0);
    wr(`PWMTB_OFF_MASK, 16'h0);
  endtask : t_irq
  // Special trigger once per period at compare value 1
  task t_special;
    wr(`PWMTB_OFF_SPECIAL, 16'h1);
    run(16'h2, ctl(1'b1, 4'h0, 2'h0, 2'h0));
    s = spCnt;
    repeat (31) @(posedge clk);
    check(16'(spCnt - s), 16'd10);
    wr(`PWMTB_OFF_CONTROL, 16'h0);
  endtask : t_special
  task t_zero;
    wr(`PWMTB_OFF_SPECIAL, 16'h0);
    run(16'h0, ctl(1'b1, 4'h0, 2'h0, 2'h0));
    n = evCnt;
    s = spCnt;
    wr(`PWMTB_OFF_PERIOD, 16'h5);
    repeat (30) @(posedge clk);
    check(16'(evCnt - n), 16'h0);
    check(16'(spCnt - s), 16'h0);
    check({1'b0, timeBaseCount}, 16'h0);
  endtask : t_zero

  // ============================================================
  // Verdict and main sequence
  task give_verdict;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict;
  end

  // Reset, then every scenario in turn
  initial begin
    reset       = 1'b1;
    address     = 4'h0;
    writeData   = 16'h0;
    writeStrobe = 1'b0;
    readStrobe  = 1'b0;
    n_fail      = 0;
    tests_run   = 0;
    evCnt       = 0;
    spCnt       = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_free;
    t_stop;
    t_single;
    t_updown;
    t_double;
    t_irq;
    t_special;
    t_zero;
    give_verdict;
  end
endmodule : test_pwm_time_base
